// *** rtl/crs_map.svh ***
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
// condition flag bit positions
`define CRS_FLAG_H 4
`define CRS_FLAG_I 3
`define CRS_FLAG_N 2
`define CRS_FLAG_Z 1
`define CRS_FLAG_C 0
// reset values
`define CRS_FLAGS_RST 8'hE8
`define CRS_SP_RST 16'h00FF
`define CRS_SP_FIXED 10'h003
`define CRS_BYTE_RST 8'h00
`define CRS_PC_RST 16'h0000
// stack geometry
`define CRS_SP_LOW_BITS 6
`define CRS_CALL_BYTES 2
`define CRS_IRQ_BYTES 5
`endif

// *** rtl/crs_pkg.sv ***
package crs_pkg;
  // register selected for a write or a stack transfer
  typedef enum logic [2:0] {
    CRS_SEL_ACC = 3'h0,
    CRS_SEL_IDX_X = 3'h1,
    CRS_SEL_IDX_Y = 3'h2,
    CRS_SEL_FLAGS = 3'h3,
    CRS_SEL_PC_LOW = 3'h4,
    CRS_SEL_PC_HIGH = 3'h5,
    CRS_SEL_SPL = 3'h6,
    CRS_SEL_NONE = 3'h7
  } crs_sel_t;

  // stack pointer operation
  typedef enum logic [2:0] {
    CRS_SP_HOLD = 3'h0,
    CRS_SP_PUSH = 3'h1,
    CRS_SP_POP = 3'h2,
    CRS_SP_RESET = 3'h3,
    CRS_SP_LOAD = 3'h4
  } crs_spop_t;

  // interrupt sequencing state
  typedef enum logic [2:0] {
    CRS_STATE_RUN = 3'h0,
    CRS_STATE_PUSH = 3'h1,
    CRS_STATE_POP = 3'h2
  } crs_state_t;

  // alu result and flag update request from the decoder
  typedef struct packed {
    logic wr;
    crs_sel_t dst;
    logic [7:0] data;
    logic upd_nz;
    logic upd_h;
    logic h_in;
    logic upd_c;
    logic c_in;
  } crs_result_t;

  // flag control from the decoder
  typedef struct packed {
    logic set_i;
    logic clr_i;
    logic set_c;
    logic clr_c;
  } crs_flagop_t;

  // context bytes
  typedef struct packed {
    logic [7:0] pc_high;
    logic [7:0] pc_low;
    logic [7:0] idx_x;
    logic [7:0] acc;
    logic [7:0] flags;
  } crs_ctx_t;
endpackage

// *** rtl/crs_stack_mem.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// stack ram, registered read
// ------------------------------------------------------------
module crs_stack_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [5:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:63];

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule

// *** rtl/crs_regset.sv ***
`timescale 1ns/1ps
`include "crs_map.svh"
// Notes on behaviour
// - eight-bit accumulator holds alu operands and results.
// - second index register is never saved or restored by interrupts.
// - sixteen-bit program counter built from low and high byte.
// - half carry set on bit3 to bit4 carry during add, else cleared.
// - mask flag set on interrupt entry or software; cleared by software or return.
// - requests during mask are held pending until unmasked.
// - clearing mask inside a routine services pending regardless of priority.
// - negative flag copies result bit seven.
// - zero flag set when result is zero.
// - carry flag from arithmetic, set/clear instructions, tests, shifts, rotates.
// - condition flags can be pushed to and popped from the stack.
// - stack pointer addresses next free byte; post-decrement push, pre-increment pop.
// - upper ten pointer bits fixed; reset or instruction sets low six bits.
// - pointer wraps silently at both stack limits.
// - pointer low byte is loadable and readable.
// - interrupt entry stores program counter low first at current pointer.
// - call takes two stack bytes, interrupt context five; call and ret inputs are unused, so only the five-byte context is stacked.
module crs_regset (
  input wire logic clk,
  input wire logic rst_n,
  input crs_pkg::crs_result_t result,
  input crs_pkg::crs_flagop_t flag_op,
  input wire logic pc_wr,
  input wire logic [15:0] pc_next,
  input crs_pkg::crs_spop_t sp_op,
  input wire logic [7:0] sp_load,
  input crs_pkg::crs_sel_t push_sel,
  input crs_pkg::crs_sel_t pop_sel,
  input wire logic call,
  input wire logic ret,
  input wire logic irq_req,
  input wire logic trap_req,
  input wire logic irq_return,
  output logic [7:0] acc_q,
  output logic [7:0] idx_x_q,
  output logic [7:0] idx_y_q,
  output logic [15:0] pc_q,
  output logic [7:0] flags_q,
  output logic [15:0] stack_pointer_q,
  output logic [7:0] stack_data_q,
  output logic irq_pending_q,
  output logic irq_take_q,
  output logic busy_q
);
  import crs_pkg::*;

  // ------------------------------------------------------------
  // internal state
  // ------------------------------------------------------------
  crs_state_t state_q;
  logic [2:0] ctx_cnt_q;
  logic [5:0] sp_low_q;
  logic [5:0] sp_d;
  logic mem_we;
  logic [5:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [5:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic pop_d1_q;
  crs_sel_t pop_sel_q;
  logic [7:0] acc_d;
  logic [7:0] flags_d;
  crs_ctx_t ctx;

  // context byte in push order
  function automatic logic [7:0] ctx_byte(input crs_ctx_t c, input logic [2:0] n);
    case (n)
      3'h0: ctx_byte = c.pc_low;
      3'h1: ctx_byte = c.pc_high;
      3'h2: ctx_byte = c.idx_x;
      3'h3: ctx_byte = c.acc;
      3'h4: ctx_byte = c.flags;
      default: ctx_byte = 8'h00;
    endcase
  endfunction

  // selected register value for a push
  function automatic logic [7:0] sel_byte(input crs_sel_t s, input crs_ctx_t c,
                                          input logic [7:0] y);
    case (s)
      CRS_SEL_ACC: sel_byte = c.acc;
      CRS_SEL_IDX_X: sel_byte = c.idx_x;
      CRS_SEL_IDX_Y: sel_byte = y;
      CRS_SEL_FLAGS: sel_byte = c.flags;
      CRS_SEL_PC_LOW: sel_byte = c.pc_low;
      CRS_SEL_PC_HIGH: sel_byte = c.pc_high;
      default: sel_byte = 8'h00;
    endcase
  endfunction

  assign ctx = '{pc_high: pc_q[15:8], pc_low: pc_q[7:0], idx_x: idx_x_q, acc: acc_q,
                 flags: flags_q};

  // ------------------------------------------------------------
  // stack memory
  // ------------------------------------------------------------
  crs_stack_mem u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // write at current pointer, read one above it
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = sp_low_q;
    mem_wdata = 8'h00;
    if (state_q == CRS_STATE_PUSH) begin
      mem_we = 1'b1;
      mem_wdata = ctx_byte(ctx, ctx_cnt_q);
    end else if (sp_op == CRS_SP_PUSH) begin
      mem_we = 1'b1;
      mem_wdata = sel_byte(push_sel, ctx, idx_y_q);
    end
  end
  assign mem_raddr = sp_low_q + 6'h01;

  // ------------------------------------------------------------
  // stack pointer
  // ------------------------------------------------------------
  always_comb begin
    sp_d = sp_low_q;
    if (state_q == CRS_STATE_PUSH) begin
      sp_d = sp_low_q - 6'h01;
    end else if (state_q == CRS_STATE_POP) begin
      sp_d = sp_low_q + 6'h01;
    end else begin
      case (sp_op)
        CRS_SP_PUSH: sp_d = sp_low_q - 6'h01;
        CRS_SP_POP: sp_d = sp_low_q + 6'h01;
        CRS_SP_RESET: sp_d = 6'h3F;
        CRS_SP_LOAD: sp_d = sp_load[5:0];
        default: sp_d = sp_low_q;
      endcase
    end
  end

  // pointer register, upper bits constant
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp_low_q <= 6'h3F;
    end else begin
      sp_low_q <= sp_d;
    end
  end

  // visible pointer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_pointer_q <= `CRS_SP_RST;
    end else begin
      stack_pointer_q <= {`CRS_SP_FIXED, sp_d};
    end
  end

  // ------------------------------------------------------------
  // interrupt entry and return sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= CRS_STATE_RUN;
      ctx_cnt_q <= 3'h0;
    end else begin
      case (state_q)
        CRS_STATE_RUN: begin
          ctx_cnt_q <= 3'h0;
          if (trap_req || (irq_pending_q && !flags_q[`CRS_FLAG_I])) begin
            state_q <= CRS_STATE_PUSH;
          end else if (irq_return) begin
            state_q <= CRS_STATE_POP;
            ctx_cnt_q <= 3'h4;
          end
        end
        CRS_STATE_PUSH: begin
          ctx_cnt_q <= ctx_cnt_q + 3'h1;
          if (ctx_cnt_q == 3'(`CRS_IRQ_BYTES - 1)) begin
            state_q <= CRS_STATE_RUN;
          end
        end
        CRS_STATE_POP: begin
          ctx_cnt_q <= ctx_cnt_q - 3'h1;
          if (ctx_cnt_q == 3'h0) begin
            state_q <= CRS_STATE_RUN;
          end
        end
        default: state_q <= CRS_STATE_RUN;
      endcase
    end
  end

  // pending latch, set wins over the service clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_pending_q <= 1'b0;
    end else if (irq_req) begin
      irq_pending_q <= 1'b1;
    end else if (state_q == CRS_STATE_RUN && !trap_req && !flags_q[`CRS_FLAG_I]) begin
      irq_pending_q <= 1'b0;
    end
  end

  // entry pulse and busy indication
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_take_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      irq_take_q <= state_q == CRS_STATE_RUN &&
                    (trap_req || (irq_pending_q && !flags_q[`CRS_FLAG_I]));
      busy_q <= state_q != CRS_STATE_RUN || irq_return || trap_req ||
                (irq_pending_q && !flags_q[`CRS_FLAG_I]);
    end
  end

  // popped byte arrives one cycle later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pop_d1_q <= 1'b0;
      pop_sel_q <= CRS_SEL_NONE;
    end else if (state_q == CRS_STATE_POP) begin
      pop_d1_q <= 1'b1;
      case (ctx_cnt_q)
        3'h4: pop_sel_q <= CRS_SEL_FLAGS;
        3'h3: pop_sel_q <= CRS_SEL_ACC;
        3'h2: pop_sel_q <= CRS_SEL_IDX_X;
        3'h1: pop_sel_q <= CRS_SEL_PC_HIGH;
        default: pop_sel_q <= CRS_SEL_PC_LOW;
      endcase
    end else begin
      pop_d1_q <= sp_op == CRS_SP_POP;
      pop_sel_q <= pop_sel;
    end
  end

  // stack data output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_data_q <= `CRS_BYTE_RST;
    end else begin
      stack_data_q <= mem_rdata;
    end
  end

  // ------------------------------------------------------------
  // data registers
  // ------------------------------------------------------------
  always_comb begin
    acc_d = acc_q;
    if (pop_d1_q && pop_sel_q == CRS_SEL_ACC) begin
      acc_d = mem_rdata;
    end else if (result.wr && result.dst == CRS_SEL_ACC) begin
      acc_d = result.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= `CRS_BYTE_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // index registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idx_x_q <= `CRS_BYTE_RST;
      idx_y_q <= `CRS_BYTE_RST;
    end else begin
      if (pop_d1_q && pop_sel_q == CRS_SEL_IDX_X) begin
        idx_x_q <= mem_rdata;
      end else if (result.wr && result.dst == CRS_SEL_IDX_X) begin
        idx_x_q <= result.data;
      end
      if (pop_d1_q && pop_sel_q == CRS_SEL_IDX_Y) begin
        idx_y_q <= mem_rdata;
      end else if (result.wr && result.dst == CRS_SEL_IDX_Y) begin
        idx_y_q <= result.data;
      end
    end
  end

  // program counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_q <= `CRS_PC_RST;
    end else if (pop_d1_q && pop_sel_q == CRS_SEL_PC_HIGH) begin
      pc_q[15:8] <= mem_rdata;
    end else if (pop_d1_q && pop_sel_q == CRS_SEL_PC_LOW) begin
      pc_q[7:0] <= mem_rdata;
    end else if (pc_wr) begin
      pc_q <= pc_next;
    end
  end

  // ------------------------------------------------------------
  // condition flags
  // ------------------------------------------------------------
  always_comb begin
    flags_d = flags_q;
    if (pop_d1_q && pop_sel_q == CRS_SEL_FLAGS) begin
      flags_d = mem_rdata;
    end else if (result.wr && result.dst == CRS_SEL_FLAGS) begin
      flags_d = result.data;
    end else begin
      if (result.wr && result.upd_nz) begin
        flags_d[`CRS_FLAG_N] = result.data[7];
        flags_d[`CRS_FLAG_Z] = result.data == 8'h00;
      end
      if (result.upd_h) begin
        flags_d[`CRS_FLAG_H] = result.h_in;
      end
      if (result.upd_c) begin
        flags_d[`CRS_FLAG_C] = result.c_in;
      end
      if (flag_op.set_c) begin
        flags_d[`CRS_FLAG_C] = 1'b1;
      end else if (flag_op.clr_c) begin
        flags_d[`CRS_FLAG_C] = 1'b0;
      end
      if (flag_op.set_i) begin
        flags_d[`CRS_FLAG_I] = 1'b1;
      end else if (flag_op.clr_i) begin
        flags_d[`CRS_FLAG_I] = 1'b0;
      end
    end
    if (state_q == CRS_STATE_PUSH && ctx_cnt_q == 3'(`CRS_IRQ_BYTES - 1)) begin
      flags_d[`CRS_FLAG_I] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= `CRS_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule

// *** tb/crs_regset_asserts.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker for the core register set
// ------------------------------------------------------------
module crs_regset_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input crs_pkg::crs_result_t result,
  input crs_pkg::crs_flagop_t flag_op,
  input crs_pkg::crs_spop_t sp_op,
  input wire logic [7:0] sp_load,
  input wire logic trap_req,
  input logic [7:0] flags_q,
  input logic [15:0] stack_pointer_q,
  input logic [7:0] idx_y_q,
  input logic irq_take_q,
  input logic busy_q
);
  import crs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // pointer low bits seen when an interrupt entry starts
  logic [5:0] sp_take_q;
  always_ff @(posedge clk) begin
    if (irq_take_q) begin
      sp_take_q <= stack_pointer_q[5:0];
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_sp_fixed_bits: assert property (stack_pointer_q[15:6] == 10'h003)
    else $error("stack pointer upper bits moved");
  chk_sp_after_reset: assert property ($past(!rst_n) |-> stack_pointer_q == 16'h00FF)
    else $error("stack pointer wrong after reset");
  chk_nz_from_result: assert property ((!busy_q && result.wr && result.upd_nz) |=>
    (flags_q[2] == $past(result.data[7])) && (flags_q[1] == ($past(result.data) == 8'h00)))
    else $error("negative or zero flag wrong");
  chk_half_carry_upd: assert property ((!busy_q && result.wr && result.upd_h) |=>
    flags_q[4] == $past(result.h_in))
    else $error("half carry flag wrong");
  chk_carry_set_op: assert property ((!busy_q && flag_op.set_c) |=> flags_q[0])
    else $error("carry not set");
  chk_push_decrement: assert property ((!busy_q && sp_op == CRS_SP_PUSH) |=>
    stack_pointer_q[5:0] == $past(stack_pointer_q[5:0]) - 6'h01)
    else $error("push did not step pointer down");
  chk_pop_increment: assert property ((!busy_q && sp_op == CRS_SP_POP) |=>
    stack_pointer_q[5:0] == $past(stack_pointer_q[5:0]) + 6'h01)
    else $error("pop did not step pointer up");
  chk_sp_load_low: assert property ((!busy_q && sp_op == CRS_SP_LOAD) |=>
    stack_pointer_q[5:0] == $past(sp_load[5:0]))
    else $error("pointer load wrong");
  chk_sp_reset_op: assert property ((!busy_q && sp_op == CRS_SP_RESET) |=>
    stack_pointer_q == 16'h00FF)
    else $error("pointer reset instruction wrong");
  chk_ctx_five_bytes: assert property (irq_take_q |-> ##[5:7]
    stack_pointer_q[5:0] == sp_take_q - 6'h05)
    else $error("entry did not take five bytes");
  chk_entry_sets_mask: assert property (irq_take_q |-> ##[1:7] flags_q[3])
    else $error("mask not set on entry");
  chk_second_index_kept: assert property (busy_q |=> idx_y_q == $past(idx_y_q))
    else $error("second index changed by context transfer");
  chk_masked_no_take: assert property ((flags_q[3] && !busy_q && !trap_req &&
    !$past(trap_req) && !flag_op.clr_i && !irq_take_q) |=> !irq_take_q)
    else $error("interrupt taken while masked");

  // main scenarios
  cov_entry: cover property (irq_take_q);
  cov_push_wrap: cover property (sp_op == CRS_SP_PUSH && stack_pointer_q == 16'h00C0);
  cov_done: cover property ($fell(busy_q));
endmodule

bind crs_regset crs_regset_asserts u_chk (.clk(clk), .rst_n(rst_n), .result(result),
  .flag_op(flag_op), .sp_op(sp_op), .sp_load(sp_load), .trap_req(trap_req),
  .flags_q(flags_q), .stack_pointer_q(stack_pointer_q), .idx_y_q(idx_y_q),
  .irq_take_q(irq_take_q), .busy_q(busy_q));

// *** tb/crs_regset_bench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module crs_regset_bench;
  import crs_pkg::*;
  typedef struct packed {
    crs_result_t result;
    crs_flagop_t flag_op;
    logic pc_wr;
    logic [15:0] pc_next;
    crs_spop_t sp_op;
    logic [7:0] sp_load;
    crs_sel_t push_sel;
    crs_sel_t pop_sel;
    logic irq_req;
    logic irq_return;
    logic trap_req;
  } crs_drv_t;
  typedef struct {int due; int what; logic [15:0] val;} crs_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  crs_drv_t drv = '0;
  logic [7:0] acc_q, idx_x_q, idx_y_q, flags_q, stack_data_q;
  logic [15:0] pc_q, stack_pointer_q;
  logic irq_pending_q, irq_take_q, busy_q;
  int num_errors = 0;
  int tests_run = 0;
  int ncyc = 0;
  crs_note_t notes[$];
  string nm [8] = '{"pending", "stack_data", "sp", "flags", "pc", "y", "x", "acc"};
  wire [127:0] obs = {8'h00, acc_q, 8'h00, idx_x_q, 8'h00, idx_y_q, pc_q, 8'h00, flags_q,
    stack_pointer_q, 8'h00, stack_data_q, 14'h0000, irq_take_q, irq_pending_q};

  // clock
  always #25 clk = ~clk;

  crs_regset DUT (.clk(clk), .rst_n(rst_n), .result(drv.result), .flag_op(drv.flag_op),
    .pc_wr(drv.pc_wr), .pc_next(drv.pc_next), .sp_op(drv.sp_op), .sp_load(drv.sp_load),
    .push_sel(drv.push_sel), .pop_sel(drv.pop_sel), .call(1'b0), .ret(1'b0),
    .irq_req(drv.irq_req), .trap_req(drv.trap_req), .irq_return(drv.irq_return),
    .acc_q(acc_q), .idx_x_q(idx_x_q), .idx_y_q(idx_y_q), .pc_q(pc_q), .flags_q(flags_q),
    .stack_pointer_q(stack_pointer_q), .stack_data_q(stack_data_q),
    .irq_pending_q(irq_pending_q), .irq_take_q(irq_take_q), .busy_q(busy_q));

  // ------------------------------------------------------------
  // monitor: compares due notes on the falling edge
  // ------------------------------------------------------------
  always @(negedge clk) begin
    ncyc = ncyc + 1;
    while (notes.size() > 0 && notes[0].due <= ncyc) begin
      `CHK(nm[notes[0].what], notes[0].val, obs[notes[0].what*16 +: 16])
      void'(notes.pop_front());
    end
  end

  // ------------------------------------------------------------
  // driver tasks
  // ------------------------------------------------------------
  task automatic expect_out(int w, logic [15:0] v, int lat);
    notes.push_back('{ncyc + 1 + lat, w, v});
  endtask
  task automatic go(crs_drv_t d);
    @(posedge clk);
    drv <= d;
  endtask
  task automatic idle(int n);
    repeat (n) go('0);
  endtask
  task automatic alu(crs_sel_t s, logic [7:0] v, logic h, logic c);
    crs_drv_t d;
    d = '0;
    d.result = '{1'b1, s, v, 1'b1, 1'b1, h, 1'b1, c};
    go(d);
  endtask
  task automatic spop(crs_spop_t o, crs_sel_t s, logic [15:0] e);
    crs_drv_t d;
    d = '0;
    d.sp_op = o;
    d.push_sel = s;
    d.pop_sel = s;
    go(d);
    expect_out(2, e, 1);
  endtask
  task automatic wait_done();
    int n;
    logic hi;
    n = 0;
    hi = 1'b0;
    while (n < 20 && !(hi && busy_q === 1'b0)) begin
      @(negedge clk);
      hi = hi | (busy_q === 1'b1);
      n++;
    end
    `CHK("busy_done", 1'b1, logic'(n < 20))
    idle(3);
  endtask
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (600) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    conclude();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    crs_drv_t d;
    crs_flagop_t fops [5];
    logic [7:0] fl, dat, accv, pushed;
    logic h, c;
    logic [15:0] pcv;
    fops = '{4'h2, 4'h1, 4'h3, 4'h4, 4'h8};
    void'($urandom(32'hD436B7DD));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    expect_out(2, 16'h00FF, 0);
    expect_out(3, 16'h00E8, 0);
    expect_out(7, 16'h0000, 0);
    fl = 8'hE8;
    // alu writes to accumulator and both index registers, boundary bytes first
    for (int i = 0; i < 12; i++) begin
      dat = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'($urandom());
      h = 1'($urandom());
      c = 1'($urandom());
      if (i % 3 == 0) accv = dat;
      alu(crs_sel_t'(i % 3), dat, h, c);
      fl = {fl[7:5], h, fl[3], dat[7], dat == 8'h00, c};
      expect_out(7 - i % 3, {8'h00, dat}, 1);
      expect_out(3, {8'h00, fl}, 1);
    end
    // flag set and clear controls
    for (int i = 0; i < 5; i++) begin
      d = '0;
      d.flag_op = fops[i];
      go(d);
      if (fops[i].set_c) fl[0] = 1'b1; else if (fops[i].clr_c) fl[0] = 1'b0;
      if (fops[i].set_i) fl[3] = 1'b1; else if (fops[i].clr_i) fl[3] = 1'b0;
      expect_out(3, {8'h00, fl}, 1);
    end
    d = '0;
    d.pc_wr = 1'b1;
    d.pc_next = 16'($urandom());
    pcv = d.pc_next;
    go(d);
    expect_out(4, pcv, 1);
    // stack wrap at both limits, flags through the stack
    pushed = fl;
    spop(CRS_SP_LOAD, CRS_SEL_NONE, 16'h00C0);
    spop(CRS_SP_PUSH, CRS_SEL_FLAGS, 16'h00FF);
    spop(CRS_SP_PUSH, CRS_SEL_ACC, 16'h00FE);
    d = '0;
    d.flag_op = 4'h4;
    go(d);
    spop(CRS_SP_POP, CRS_SEL_IDX_X, 16'h00FF);
    spop(CRS_SP_POP, CRS_SEL_FLAGS, 16'h00C0);
    idle(3);
    expect_out(6, {8'h00, accv}, 0);
    expect_out(3, {8'h00, pushed}, 0);
    fl = pushed;
    // masked request stays pending
    d = '0;
    d.irq_req = 1'b1;
    go(d);
    expect_out(0, 16'h0001, 1);
    idle(4);
    expect_out(0, 16'h0001, 0);
    expect_out(2, 16'h00C0, 0);
    d = '0;
    d.flag_op = 4'h4;
    go(d);
    expect_out(0, 16'h0002, 2);
    idle(1);
    fl[3] = 1'b0;
    wait_done();
    expect_out(2, 16'h00FB, 0);
    expect_out(3, {8'h00, fl | 8'h08}, 0);
    expect_out(1, {8'h00, fl}, 0);
    expect_out(0, 16'h0000, 0);
    alu(CRS_SEL_IDX_Y, 8'h5A, 1'b0, 1'b0);
    d = '0;
    d.irq_return = 1'b1;
    go(d);
    idle(1);
    wait_done();
    expect_out(2, 16'h00C0, 0);
    expect_out(3, {8'h00, fl}, 0);
    expect_out(4, pcv, 0);
    expect_out(6, {8'h00, accv}, 0);
    expect_out(7, {8'h00, accv}, 0);
    expect_out(5, 16'h005A, 0);
    // software trap enters while masked, then pointer reset
    d = '0;
    d.flag_op = 4'h8;
    go(d);
    d = '0;
    d.trap_req = 1'b1;
    go(d);
    expect_out(0, 16'h0002, 1);
    idle(1);
    wait_done();
    expect_out(2, 16'h00FB, 0);
    expect_out(3, {8'h00, fl | 8'h08}, 0);
    expect_out(1, {8'h00, fl | 8'h08}, 0);
    spop(CRS_SP_RESET, CRS_SEL_NONE, 16'h00FF);
    idle(3);
    conclude();
  end
endmodule
